// file: pdrb_builder.sv
`timescale 1ns/1ps
// Functional notes
// - checksum failure reports firmware level all zeros
// - two-char loadable code level field
// - two-char minimum driver level field
// - fixed function description text field
// - memory prefix plus three decimal digits
// - cache prefix, three digits, zeros without cache
// - identifier prefix, sixteen hex chars, lower id
// - last identifier character always even
// - length byte is halved inclusive descriptor size
// - every descriptor has even byte count
// - odd contents get one trailing null
// - header length is halved descriptor total
// - two crc header bytes are zero
// - part numbers eight chars, zero-filled left
// - change level ten chars, zero-filled left
// - firmware level is twelve characters
// - plant field is six characters
module pdrb_builder
  import pdrb_pkg::*;
#(
  parameter logic [87:0] DESC_FUNC_TEXT = 88'h5354_4F52_4147_452D_4144_50 // arbitrary text
)
(
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               nrst_i,
  // build control
  input  wire logic               build_i,
  output logic                    busy_o,
  output logic                    ready_o,
  // field sources, ascii, first character in the top byte
  input  wire logic [63:0]        card_part_i,
  input  wire logic [63:0]        unit_part_i,
  input  wire logic [63:0]        unit_serial_i,
  input  wire logic [79:0]        change_level_i,
  input  wire logic [47:0]        plant_i,
  input  wire logic [95:0]        fw_level_i,
  input  wire logic               checksum_fail_i,
  input  wire logic [15:0]        loadable_level_i,
  input  wire logic [15:0]        driver_level_i,
  // sizes in megabytes, binary
  input  wire logic [9:0]         memory_mb_i,
  input  wire logic               cache_present_i,
  input  wire logic [9:0]         cache_mb_i,
  // node identifiers, binary
  input  wire logic [63:0]        node_id_a_i,
  input  wire logic [63:0]        node_id_b_i,
  // record read port
  input  wire logic [ADDR_W-1:0]  rd_addr_i,
  output logic [7:0]              rd_data_o
);

  // null bytes become '0' so short right-justified values read zero-filled
  function automatic logic [79:0] zero_fill(input logic [79:0] v);
    logic [79:0] r;
    r = v;
    for (int i = 0; i < 10; i++) begin
      if (v[i*8 +: 8] == NULL_BYTE) begin
        r[i*8 +: 8] = ASCII_ZERO;
      end
    end
    return r;
  endfunction : zero_fill

  // one nibble to an ascii hex character
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (8'(n) > NINE_NIBBLE) ? 8'(n) + HEX_ALPHA : 8'(n) + ASCII_ZERO;
  endfunction : hex_char

  // binary size to three ascii decimal digits, saturating
  function automatic logic [23:0] dec3(input logic [9:0] v);
    logic [9:0] s;
    s = (v > DEC_MAX) ? DEC_MAX : v;
    return {8'(s / 10'd100) + ASCII_ZERO,
            8'((s / 10'd10) % 10'd10) + ASCII_ZERO,
            8'(s % 10'd10) + ASCII_ZERO};
  endfunction : dec3

  // 64-bit value to sixteen hex characters, most significant first
  function automatic logic [127:0] hex16(input logic [63:0] v);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i*8 +: 8] = hex_char(v[i*4 +: 4]);
    end
    return r;
  endfunction : hex16

  // field assembly, continuous from the inputs
  logic [95:0]   fw_text;       // firmware level as reported
  logic [23:0]   mem_digits;    // memory size digits
  logic [23:0]   cache_digits;  // cache size digits
  logic [63:0]   node_id_low;   // lower node identifier
  logic [127:0]  node_id_text;  // identifier characters
  logic [79:0]   card_fill;     // card part number, zero-filled, top two bytes unused
  logic [79:0]   unit_fill;     // unit part number, zero-filled, top two bytes unused
  logic [CONTENT_BYTES*8-1:0] content; // every field content, record order

  assign fw_text      = checksum_fail_i ? {12{ASCII_ZERO}} : fw_level_i;
  assign mem_digits   = dec3(memory_mb_i);
  assign cache_digits = cache_present_i ? dec3(cache_mb_i) : {3{ASCII_ZERO}};
  assign node_id_low  = (node_id_a_i < node_id_b_i) ? node_id_a_i : node_id_b_i;
  assign node_id_text = hex16(node_id_low & NODE_ID_EVEN_MASK);
  // a function result cannot be sliced in place, so the filled values get names
  assign card_fill    = zero_fill({16'h0000, card_part_i});
  assign unit_fill    = zero_fill({16'h0000, unit_part_i});

  assign content = {
    card_fill[63:0],
    unit_fill[63:0],
    unit_serial_i,
    zero_fill(change_level_i),
    plant_i,
    fw_text,
    loadable_level_i,
    driver_level_i,
    DESC_FUNC_TEXT,
    MEM_PREFIX, mem_digits,
    CACHE_PREFIX, cache_digits,
    NODE_ID_PREFIX, node_id_text};

  // sequencer state
  pdrb_state_e       state_reg, state_next;   // build step
  logic [3:0]        desc_reg, desc_next;     // current descriptor
  logic [7:0]        cnt_reg, cnt_next;       // byte count within a step
  logic [7:0]        ci_reg, ci_next;         // running content index
  logic [ADDR_W-1:0] wptr_reg;                // record write pointer
  logic              ready_reg, busy_reg;     // status flags
  logic [7:0]        wbyte;                   // byte written this cycle
  logic [7:0]        field_len;               // current content length
  logic [15:0]       keyword;                 // current keyword pair
  logic [7:0]        hdr_byte;                // header byte at cnt_reg
  logic [7:0]        body_byte;               // content byte at ci_reg
  logic              last_desc;               // current is the final descriptor
  logic              active;                  // a byte is produced this cycle

  assign field_len = FIELD_LEN[desc_reg];
  assign keyword   = KEYWORDS[desc_reg];
  assign last_desc = (32'(desc_reg) == DESC_NUM - 1);
  assign active    = (state_reg != ST_IDLE);
  assign body_byte = content[(CONTENT_BYTES - 1 - 32'(ci_reg)) * 8 +: 8];

  // header: letters, spare zero, halved length, two zero crc bytes
  assign hdr_byte = (cnt_reg < HDR_SPARE_POS) ? HDR_TAG[(2 - 32'(cnt_reg)) * 8 +: 8]
                  : (cnt_reg == HDR_LEN_POS)  ? REC_HALF
                  : NULL_BYTE;

  // next state and the byte produced in each step
  always_comb begin
    state_next = state_reg;
    desc_next  = desc_reg;
    cnt_next   = cnt_reg;
    ci_next    = ci_reg;
    wbyte      = NULL_BYTE;
    case (state_reg)
      ST_IDLE: begin
        if (build_i) begin
          state_next = ST_HDR;
          desc_next  = '0;
          cnt_next   = '0;
          ci_next    = '0;
        end
      end
      ST_HDR: begin
        wbyte    = hdr_byte;
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == HDR_LAST_POS) begin
          state_next = ST_MARK;
        end
      end
      ST_MARK: begin
        wbyte      = DESC_MARK;
        state_next = ST_KEY_HI;
      end
      ST_KEY_HI: begin
        wbyte      = keyword[15:8];
        state_next = ST_KEY_LO;
      end
      ST_KEY_LO: begin
        wbyte      = keyword[7:0];
        state_next = ST_LEN;
      end
      ST_LEN: begin
        wbyte      = desc_half(field_len);
        cnt_next   = '0;
        state_next = ST_BODY;
      end
      ST_BODY: begin
        wbyte    = body_byte;
        cnt_next = cnt_reg + 8'h01;
        ci_next  = ci_reg + 8'h01;
        if (cnt_reg == field_len - 8'h01) begin
          // header is four bytes, so an odd content needs one pad to stay even
          if (field_len[0]) begin
            state_next = ST_PAD;
          end else begin
            state_next = last_desc ? ST_IDLE : ST_MARK;
            desc_next  = desc_reg + 4'h1;
          end
        end
      end
      ST_PAD: begin
        wbyte      = NULL_BYTE;
        state_next = last_desc ? ST_IDLE : ST_MARK;
        desc_next  = desc_reg + 4'h1;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      desc_reg  <= '0;
      cnt_reg   <= '0;
      ci_reg    <= '0;
    end else begin
      state_reg <= state_next;
      desc_reg  <= desc_next;
      cnt_reg   <= cnt_next;
      ci_reg    <= ci_next;
    end
  end

  // write pointer: restarts with each build, so a rebuild overwrites in place
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr_reg <= '0;
    end else if (!active) begin
      wptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_reg + 8'h01;
    end
  end

  // status: ready drops when a build starts, rises when the last byte is stored
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      busy_reg <= (state_next != ST_IDLE);
      if (!active && build_i) begin
        ready_reg <= 1'b0;
      end else if (active && state_next == ST_IDLE) begin
        ready_reg <= 1'b1;
      end
    end
  end

  // record store
  pdrb_mem_if mem_bus ();

  assign mem_bus.wr_en   = active;
  assign mem_bus.wr_addr = wptr_reg;
  assign mem_bus.wr_data = wbyte;
  assign mem_bus.rd_addr = rd_addr_i;

  pdrb_store u_store (
    .clock_i (clock_i),
    .bus     (mem_bus.store)
  );

  assign busy_o    = busy_reg;
  assign ready_o   = ready_reg;
  assign rd_data_o = mem_bus.rd_data;

endmodule : pdrb_builder

// file: pdrb_builder_monitor.sv
`timescale 1ns/1ps
// watches build timing and the stored record bytes at the read port
module pdrb_builder_monitor
  import pdrb_pkg::*;
(
  // clock and reset
  input wire logic              clock_i,
  input wire logic              nrst_i,
  // build control
  input wire logic              build_i,
  input wire logic              busy_o,
  input wire logic              ready_o,
  input wire logic              checksum_fail_i,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr_i,
  input wire logic [7:0]        rd_data_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic [8:0] busy_cnt_reg; // busy cycles of the running build
  // cleared while idle, so a build taken right after the finish counts from zero again
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt_reg <= 9'h000;
    end else if (busy_o) begin
      busy_cnt_reg <= busy_cnt_reg + 9'h001;
    end else begin
      busy_cnt_reg <= 9'h000;
    end
  end
  // request accepted by an idle builder
  sequence taken_s;
    build_i && !busy_o;
  endsequence
  // finished record read at one address
  sequence rd_s(logic [7:0] a);
    ready_o && !busy_o && rd_addr_i == a;
  endsequence
  build_start_a: assert property (taken_s |=> busy_o && !ready_o)
    else $error("build not started");
  build_length_a: assert property ($fell(busy_o) |-> ready_o && busy_cnt_reg == 9'h0A3)
    else $error("record byte count wrong");
  hdr_tag_a: assert property (rd_s(8'h00) |=> rd_data_o == 8'h56)
    else $error("header letter wrong");
  hdr_spare_a: assert property (rd_s(8'h03) |=> rd_data_o == 8'h00)
    else $error("header spare not zero");
  rec_len_a: assert property (rd_s(8'h04) |=> rd_data_o == 8'h4E)
    else $error("record length wrong");
  crc_zero_a: assert property (ready_o && !busy_o && rd_addr_i inside {8'h05, 8'h06}
    |=> rd_data_o == 8'h00) else $error("crc byte not zero");
  // the cache descriptor is fourteen bytes, so the last mark sits at 8Bh
  desc_mark_a: assert property (ready_o && !busy_o && rd_addr_i inside {8'h07, 8'h13,
    8'h1F, 8'h2B, 8'h39, 8'h43, 8'h53, 8'h59, 8'h5F, 8'h6F, 8'h7D, 8'h8B}
    |=> rd_data_o == 8'h2A) else $error("descriptor mark missing");
  half_len_a: assert property (rd_s(8'h62) |=> rd_data_o == 8'h08)
    else $error("descriptor length wrong");
  pad_null_a: assert property (ready_o && !busy_o
    && rd_addr_i inside {8'h6E, 8'h7C, 8'h8A} |=> rd_data_o == 8'h00)
    else $error("pad byte not null");
  fw_fail_a: assert property (ready_o && !busy_o && checksum_fail_i
    && rd_addr_i inside {[8'h47:8'h52]} |=> rd_data_o == 8'h30)
    else $error("failed firmware level not zero");
  id_even_a: assert property (rd_s(8'hA2) |=> rd_data_o inside {8'h30, 8'h32, 8'h34,
    8'h36, 8'h38, 8'h41, 8'h43, 8'h45}) else $error("identifier ends odd");
endmodule : pdrb_builder_monitor

bind pdrb_builder pdrb_builder_monitor i_monitor (.clock_i, .nrst_i, .build_i, .busy_o,
  .ready_o, .checksum_fail_i, .rd_addr_i, .rd_data_o);

// file: pdrb_host_reader.sv
`timescale 1ns/1ps
// host side: walks the read port and keeps a copy of the record
module pdrb_host_reader
  import pdrb_pkg::*;
(
  // clock
  input  wire logic              clock_i,
  // read port
  input  wire logic [7:0]        rd_data_i,
  output logic      [ADDR_W-1:0] rd_addr_o
);
  logic [7:0] image [0:255]; // bytes as the host saw them
  initial rd_addr_o = '0;
  // one address per cycle; data of an address lands one edge later
  task automatic read_all();
    for (int a = 0; a <= 163; a++) begin
      @(negedge clock_i);
      if (a > 0) image[a-1] = rd_data_i;
      rd_addr_o = ADDR_W'(a);
    end
  endtask : read_all
endmodule : pdrb_host_reader

// file: pdrb_mem_if.sv
`timescale 1ns/1ps
// write and read port of the record store
interface pdrb_mem_if;
  import pdrb_pkg::*;
  logic              wr_en;   // write strobe
  logic [ADDR_W-1:0] wr_addr; // write address
  logic [7:0]        wr_data; // write byte
  logic [ADDR_W-1:0] rd_addr; // read address
  logic [7:0]        rd_data; // registered read byte
  modport builder (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport store   (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : pdrb_mem_if

// file: pdrb_pkg.sv
package pdrb_pkg;

  // record geometry
  localparam int DESC_NUM       = 12;   // descriptors after the header
  localparam int HDR_BYTES      = 7;    // fixed header length
  localparam int DESC_HDR_BYTES = 4;    // asterisk, two keyword bytes, length byte
  localparam int CONTENT_BYTES  = 105;  // all field contents, back to back
  localparam int ADDR_W         = 8;    // record store address width
  localparam int STORE_DEPTH    = 256;  // record store depth in bytes

  // fixed byte values
  localparam logic [7:0]  ASCII_ZERO   = 8'h30;      // character '0'
  localparam logic [7:0]  HEX_ALPHA    = 8'h37;      // 'A' minus ten
  localparam logic [7:0]  NINE_NIBBLE  = 8'h09;      // largest decimal nibble
  localparam logic [7:0]  DESC_MARK    = 8'h2A;      // asterisk opening a descriptor
  localparam logic [7:0]  NULL_BYTE    = 8'h00;      // pad, spare and crc byte
  localparam logic [23:0] HDR_TAG      = 24'h565044; // three header letters
  localparam logic [9:0]  DEC_MAX      = 10'h3E7;    // 999, largest three-digit size
  localparam logic [63:0] NODE_ID_EVEN_MASK = 64'hFFFF_FFFF_FFFF_FFFE; // forces even last char

  // header byte positions
  localparam logic [7:0] HDR_SPARE_POS = 8'h03;
  localparam logic [7:0] HDR_LEN_POS   = 8'h04;
  localparam logic [7:0] HDR_LAST_POS  = 8'h06;

  // ascii prefixes of the size and identifier fields
  localparam logic [47:0] MEM_PREFIX   = 48'h5344_5241_4D3D; // memory size prefix
  localparam logic [47:0] CACHE_PREFIX = 48'h4341_4348_453D; // cache size prefix
  localparam logic [31:0] NODE_ID_PREFIX = 32'h5549_443D;    // identifier prefix

  // keyword pairs, in record order
  localparam logic [0:DESC_NUM-1][15:0] KEYWORDS = {
    16'h504E, 16'h464E, 16'h534E, 16'h4543, 16'h4D46, 16'h524C,
    16'h4C4C, 16'h4444, 16'h4453, 16'h5A30, 16'h5A31, 16'h5A32};

  // content bytes per descriptor, pad excluded
  localparam logic [0:DESC_NUM-1][7:0] FIELD_LEN = {
    8'h08, 8'h08, 8'h08, 8'h0A, 8'h06, 8'h0C,
    8'h02, 8'h02, 8'h0B, 8'h09, 8'h09, 8'h14};

  // halved inclusive descriptor size; the +1 accounts for a pad byte on odd contents
  function automatic logic [7:0] desc_half(input logic [7:0] len);
    logic [8:0] total;
    total = 9'(len) + 9'(DESC_HDR_BYTES) + 9'h001;
    return total[8:1];
  endfunction : desc_half

  // halved length of all descriptors together
  function automatic logic [7:0] rec_half();
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < DESC_NUM; i++) begin
      acc = acc + desc_half(FIELD_LEN[i]);
    end
    return acc;
  endfunction : rec_half

  localparam logic [7:0] REC_HALF = rec_half();

  // build sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR, ST_MARK, ST_KEY_HI, ST_KEY_LO, ST_LEN, ST_BODY, ST_PAD
  } pdrb_state_e;

endpackage : pdrb_pkg

// file: pdrb_store.sv
`timescale 1ns/1ps
// byte store holding the assembled record; read data is registered
module pdrb_store
  import pdrb_pkg::*;
(
  // clock
  input  wire logic   clock_i,
  // port
  pdrb_mem_if.store   bus
);

  logic [7:0] mem_q [STORE_DEPTH]; // record bytes, no reset: contents valid once built
  logic [7:0] rd_reg;              // read data register

  // one write and one read per cycle
  always_ff @(posedge clock_i) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_addr] <= bus.wr_data;
    end
    rd_reg <= mem_q[bus.rd_addr];
  end

  assign bus.rd_data = rd_reg;

endmodule : pdrb_store

// file: testbench.sv
`timescale 1ns/1ps
// self-checking bench for the record builder
module testbench;
  import pdrb_pkg::*;
  localparam logic [87:0] FUNC = 88'h4449_534B_2D43_4F4E_5452_4C; // own description text
  typedef struct packed {
    logic [9:0]  mem;
    logic        cp;
    logic [9:0]  cmb;
    logic [23:0] emem;
    logic [23:0] ecache;
    logic [63:0] ida;
    logic [63:0] idb;
    logic        cks;
  } pdrb_row_s;
  // sizes, ids and checksum state beside the size text they must give
  localparam pdrb_row_s ROWS [3] = '{
    '{10'h040, 1'b1, 10'h020, 24'h303634, 24'h303332,
      64'h0000_1234_5678_9ABC, 64'h0000_1234_5678_9ABD, 1'b0},
    '{10'h3E8, 1'b0, 10'h200, 24'h393939, 24'h303030,
      64'hFFFF_FFFF_FFFF_FFFF, 64'h0123_4567_89AB_CDEF, 1'b1},
    '{10'h005, 1'b1, 10'h000, 24'h303035, 24'h303030,
      64'hFEDC_BA98_7654_3211, 64'hFEDC_BA98_7654_3211, 1'b0}};
  logic              clock_i, nrst_i, build_i, checksum_fail_i, cache_present_i, busy_o, ready_o;
  logic [63:0]       card_part_i, unit_part_i, unit_serial_i, node_id_a_i, node_id_b_i;
  logic [79:0]       change_level_i;
  logic [47:0]       plant_i;
  logic [95:0]       fw_level_i;
  logic [15:0]       loadable_level_i, driver_level_i;
  logic [9:0]        memory_mb_i, cache_mb_i;
  logic [ADDR_W-1:0] rd_addr_i;
  logic [7:0]        rd_data_o;
  logic [7:0]        body [$]; // expected bytes after the header
  int                num_errors, comparisons;
  pdrb_builder #(.DESC_FUNC_TEXT(FUNC)) i_dut (.*);
  pdrb_host_reader i_host (.clock_i, .rd_data_i(rd_data_o), .rd_addr_o(rd_addr_i));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic final_report();
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // zero fill of empty character slots
  function automatic logic [79:0] zf(input logic [79:0] v);
    for (int i = 0; i < 10; i++) begin
      if (v[8*i +: 8] == 8'h00) v[8*i +: 8] = 8'h30;
    end
    return v;
  endfunction : zf
  // appends one expected descriptor, last n bytes of v as contents
  task automatic put(input logic [15:0] k, input int n, input logic [159:0] v);
    int s;
    s = body.size();
    body.push_back(8'h2A);
    body.push_back(k[15:8]);
    body.push_back(k[7:0]);
    body.push_back(8'h00); // length byte, set once the descriptor is complete
    for (int i = n - 1; i >= 0; i--) body.push_back(v[8*i +: 8]);
    if (n % 2) body.push_back(8'h00);
    body[s+3] = 8'((body.size() - s) / 2);
  endtask : put
  // bounded wait for a finished record
  task automatic wait_ready();
    for (int n = 0; ready_o !== 1'b1; n++) begin
      if (n == 400) begin
        num_errors++;
        final_report();
      end
      @(negedge clock_i);
    end
  endtask : wait_ready
  task automatic drive(input pdrb_row_s r);
    @(negedge clock_i);
    memory_mb_i = r.mem;
    cache_present_i = r.cp;
    cache_mb_i = r.cmb;
    node_id_a_i = r.ida;
    node_id_b_i = r.idb;
    checksum_fail_i = r.cks;
  endtask : drive
  task automatic check_record(input pdrb_row_s r);
    logic [63:0]  low;
    logic [127:0] hex;
    logic [3:0]   nib;
    logic [55:0]  hdr;
    low = (r.ida < r.idb) ? r.ida : r.idb;
    low[0] = 1'b0;
    for (int i = 0; i < 16; i++) begin
      nib = low[4*i +: 4];
      hex[8*i +: 8] = (nib < 4'hA) ? 8'h30 + 8'(nib) : 8'h37 + 8'(nib);
    end
    body.delete();
    put(16'h504E, 8, 160'(zf(80'(card_part_i))));
    put(16'h464E, 8, 160'(zf(80'(unit_part_i))));
    put(16'h534E, 8, 160'(unit_serial_i));
    put(16'h4543, 10, 160'(zf(change_level_i)));
    put(16'h4D46, 6, 160'(plant_i));
    put(16'h524C, 12, 160'(r.cks ? {12{8'h30}} : fw_level_i));
    put(16'h4C4C, 2, 160'(loadable_level_i));
    put(16'h4444, 2, 160'(driver_level_i));
    put(16'h4453, 11, 160'(FUNC));
    put(16'h5A30, 9, 160'({MEM_PREFIX, r.emem}));
    put(16'h5A31, 9, 160'({CACHE_PREFIX, r.ecache}));
    put(16'h5A32, 20, {NODE_ID_PREFIX, hex});
    hdr = {24'h565044, 8'h00, 8'(body.size() / 2), 16'h0000};
    for (int i = 0; i < 7; i++) chk8(i_host.image[i], hdr[55-8*i -: 8]);
    foreach (body[i]) chk8(i_host.image[7+i], body[i]);
  endtask : check_record
  initial begin
    nrst_i = 1'b0;
    build_i = 1'b0;
    card_part_i = 64'h0000_3132_3334_3536;
    unit_part_i = 64'h3132_3334_3536_3738;
    unit_serial_i = 64'h5A39_3031_3241_4243;
    change_level_i = 80'h0000_0000_3031_3233_3441;
    plant_i = 48'h504C_4E54_3031;
    fw_level_i = 96'h3033_3031_3435_3637_3839_3130;
    loadable_level_i = 16'h3035;
    driver_level_i = 16'h3032;
    {memory_mb_i, cache_present_i, cache_mb_i, node_id_a_i, node_id_b_i} = '0;
    checksum_fail_i = 1'b0;
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    nrst_i = 1'b1;
    // ordinary builds, one per row
    foreach (ROWS[k]) begin
      drive(ROWS[k]);
      build_i = 1'b1;
      @(negedge clock_i);
      build_i = 1'b0;
      chk1(busy_o, 1'b1);
      chk1(ready_o, 1'b0);
      wait_ready();
      i_host.read_all();
      check_record(ROWS[k]);
    end
    // reset in mid-build drops both flags
    drive(ROWS[1]);
    build_i = 1'b1;
    repeat (40) @(negedge clock_i);
    nrst_i = 1'b0;
    @(negedge clock_i);
    chk1(busy_o, 1'b0);
    chk1(ready_o, 1'b0);
    nrst_i = 1'b1;
    // held request: ignored while busy, taken again right after the finish
    wait_ready();
    @(negedge clock_i);
    chk1(busy_o, 1'b1);
    chk1(ready_o, 1'b0);
    build_i = 1'b0;
    wait_ready();
    i_host.read_all();
    check_record(ROWS[1]);
    final_report();
  end
endmodule : testbench
